// ==== include/vim_map.svh ====
`ifndef VIM_MAP_SVH
`define VIM_MAP_SVH

// ----------------------------------------------------------------------------
// sizes
// ----------------------------------------------------------------------------
`define VIM_NUM_LINES 65
`define VIM_NUM_SYS 16
`define VIM_NUM_CFG_SYS 7
`define VIM_PRIO_BITS 4

// ----------------------------------------------------------------------------
// exception numbers of the fixed-priority slots
// ----------------------------------------------------------------------------
`define VIM_EXC_RESET 7'h01
`define VIM_EXC_NMI 7'h02
`define VIM_EXC_HARD 7'h03

// configurable system exceptions, in sys_req_i order
`define VIM_EXC_MEM 7'h04
`define VIM_EXC_BUS 7'h05
`define VIM_EXC_USAGE 7'h06
`define VIM_EXC_SVC 7'h0b
`define VIM_EXC_DBG 7'h0c
`define VIM_EXC_PENDSV 7'h0e
`define VIM_EXC_TICK 7'h0f

// ----------------------------------------------------------------------------
// fixed priorities, two's complement on five bits
// ----------------------------------------------------------------------------
`define VIM_PRIO_RESET 5'h1d
`define VIM_PRIO_NMI 5'h1e
`define VIM_PRIO_HARD 5'h1f

// ----------------------------------------------------------------------------
// vector table
// ----------------------------------------------------------------------------
`define VIM_LINE_VEC_BASE 32'h00000040

// ----------------------------------------------------------------------------
// shared and named maskable lines
// ----------------------------------------------------------------------------
`define VIM_LINE_SUPPLY 1
`define VIM_LINE_FLASH 4
`define VIM_LINE_USB_CAN 19
`define VIM_LINE_PIN5_9 23
`define VIM_LINE_PIN10_15 40

`endif

// ==== include/vim_pkg.sv ====
`include "vim_map.svh"

package vim_pkg;

   typedef logic signed [4:0] vim_prio_t;
   typedef logic [6:0] vim_num_t;

   // word-aligned slot: exception number times four
   function automatic logic [31:0] vec_of_num(input vim_num_t num);
      return {23'h000000, num, 2'b00};
   endfunction : vec_of_num

   function automatic vim_num_t cfg_sys_num(input int k);
      vim_num_t n;
      n = 7'h00;
      case (k)
         0: n = `VIM_EXC_MEM;
         1: n = `VIM_EXC_BUS;
         2: n = `VIM_EXC_USAGE;
         3: n = `VIM_EXC_SVC;
         4: n = `VIM_EXC_DBG;
         5: n = `VIM_EXC_PENDSV;
         6: n = `VIM_EXC_TICK;
         default: n = 7'h00;
      endcase
      return n;
   endfunction : cfg_sys_num

endpackage : vim_pkg

// ==== include/vim_arb_if.sv ====
`timescale 1ns/1ps
`default_nettype none

interface vim_arb_if #(
   parameter int N_SLOTS = 81
);
   logic [N_SLOTS-1:0] pend;
   vim_pkg::vim_prio_t prio [N_SLOTS];
   logic valid;
   vim_pkg::vim_num_t num;
   vim_pkg::vim_prio_t win_prio;

   modport ctrl (output pend, output prio, input valid, input num, input win_prio);
   modport arb (input pend, input prio, output valid, output num, output win_prio);
endinterface : vim_arb_if

`default_nettype wire

// ==== design/vim_arbiter.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// pick the pending slot with the lowest priority value
// ----------------------------------------------------------------------------
// ties go to the lower exception number; a strict compare keeps the first one
module vim_arbiter #(
   parameter int N_SLOTS = 81
) (
   vim_arb_if.arb arb
);

   always_comb begin
      arb.valid = 1'b0;
      arb.num = 7'h00;
      arb.win_prio = 5'sh0f;
      for (int i = 0; i < N_SLOTS; i++) begin
         if (arb.pend[i] && (!arb.valid || arb.prio[i] < arb.win_prio)) begin // see RULE_02
            arb.valid = 1'b1;
            arb.num = 7'(i);
            arb.win_prio = arb.prio[i];
         end
      end
   end

endmodule : vim_arbiter

`default_nettype wire

// ==== design/vim_mapper.sv ====
// How it works
// RULE_01: sixty-five maskable lines 0..64 sit after the sixteen system exception slots.
// RULE_02: each maskable line and configurable exception has a four-bit priority.
// RULE_03: maskable line n fetches its vector from 0x40 plus four times n.
// RULE_04: line 19 is the OR of usb high-priority and can transmit requests.
// RULE_05: pin lines five to nine all pend maskable line 23.
// RULE_06: pin lines ten to fifteen all pend maskable line 40.
// RULE_07: the flash controller global request pends maskable line 4.
// RULE_08: reset, nmi, hard fault have priorities -3, -2, -1, above all others.
`timescale 1ns/1ps
`default_nettype none

`include "vim_map.svh"

module vim_mapper #(
   parameter int NUM_LINES = `VIM_NUM_LINES
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic [NUM_LINES-1:0] per_req_i,
   input wire logic supply_monitor_req_i,
   input wire logic flash_req_i,
   input wire logic usb_high_prio_req_i,
   input wire logic can_tx_req_i,
   input wire logic [4:0] pin_lines_five_to_nine_req_i,
   input wire logic [5:0] pin_lines_ten_to_fifteen_req_i,
   input wire logic [NUM_LINES-1:0] line_en_i,
   input wire logic [NUM_LINES-1:0][3:0] line_prio_i,
   input wire logic nmi_i,
   input wire logic hard_fault_i,
   input wire logic [`VIM_NUM_CFG_SYS-1:0] sys_req_i,
   input wire logic [`VIM_NUM_CFG_SYS-1:0][3:0] sys_prio_i,
   input wire logic take_i,
   output logic irq_valid_o,
   output logic [6:0] irq_num_o,
   output logic [4:0] irq_prio_o,
   output logic [31:0] vec_addr_o,
   output logic [NUM_LINES-1:0] line_pend_o
);

   localparam int N_SLOTS = `VIM_NUM_SYS + NUM_LINES;

   // -------------------------------------------------------------------------
   // reset release
   // -------------------------------------------------------------------------
   logic [1:0] rst_sync;
   logic [1:0] next_rst_sync;
   logic rst_n;

   always_comb begin
      next_rst_sync = {rst_sync[0], 1'b1};
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= next_rst_sync;
      end
   end

   assign rst_n = rst_sync[1];

   // -------------------------------------------------------------------------
   // source mapping
   // -------------------------------------------------------------------------
   logic [NUM_LINES-1:0] line_req;
   logic [N_SLOTS-1:0] slot_req;
   logic [N_SLOTS-1:0] slot_en;

   vim_arb_if #(.N_SLOTS(N_SLOTS)) arb_bus ();

   always_comb begin
      line_req = per_req_i;
      line_req[`VIM_LINE_SUPPLY] = supply_monitor_req_i; // see RULE_03
      line_req[`VIM_LINE_FLASH] = flash_req_i; // see RULE_07
      line_req[`VIM_LINE_USB_CAN] = usb_high_prio_req_i | can_tx_req_i; // see RULE_04
      line_req[`VIM_LINE_PIN5_9] = |pin_lines_five_to_nine_req_i; // see RULE_05
      line_req[`VIM_LINE_PIN10_15] = |pin_lines_ten_to_fifteen_req_i; // see RULE_06
   end

   always_comb begin
      slot_req = '0;
      slot_en = '0;
      for (int i = 0; i < N_SLOTS; i++) begin
         arb_bus.prio[i] = 5'sh00;
      end
      // fixed slots cannot be masked and outrank every four-bit level
      slot_en[`VIM_EXC_RESET] = 1'b1;
      slot_req[`VIM_EXC_NMI] = nmi_i;
      slot_en[`VIM_EXC_NMI] = 1'b1;
      slot_req[`VIM_EXC_HARD] = hard_fault_i;
      slot_en[`VIM_EXC_HARD] = 1'b1;
      arb_bus.prio[`VIM_EXC_RESET] = `VIM_PRIO_RESET; // see RULE_08
      arb_bus.prio[`VIM_EXC_NMI] = `VIM_PRIO_NMI; // see RULE_08
      arb_bus.prio[`VIM_EXC_HARD] = `VIM_PRIO_HARD; // see RULE_08
      for (int k = 0; k < `VIM_NUM_CFG_SYS; k++) begin
         slot_req[vim_pkg::cfg_sys_num(k)] = sys_req_i[k];
         slot_en[vim_pkg::cfg_sys_num(k)] = 1'b1;
         arb_bus.prio[vim_pkg::cfg_sys_num(k)] = {1'b0, sys_prio_i[k]}; // see RULE_02
      end
      // line n lives in slot 16+n, so its vector is 0x40 + 4n
      for (int n = 0; n < NUM_LINES; n++) begin
         slot_req[`VIM_NUM_SYS+n] = line_req[n]; // see RULE_01
         slot_en[`VIM_NUM_SYS+n] = line_en_i[n];
         arb_bus.prio[`VIM_NUM_SYS+n] = {1'b0, line_prio_i[n]}; // see RULE_02
      end
   end

   // -------------------------------------------------------------------------
   // pending state
   // -------------------------------------------------------------------------
   logic [N_SLOTS-1:0] pend;
   logic [N_SLOTS-1:0] next_pend;
   logic taken;

   assign taken = take_i & irq_valid_o;

   always_comb begin
      next_pend = pend;
      if (taken) begin
         next_pend[irq_num_o] = 1'b0;
      end
      // a request present in the take cycle keeps its slot pending
      next_pend = next_pend | slot_req;
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         pend <= '0;
         pend[`VIM_EXC_RESET] <= 1'b1; // see RULE_08
      end else begin
         pend <= next_pend;
      end
   end

   // masked lines stay pending but are hidden from the arbiter
   assign arb_bus.pend = pend & slot_en;

   vim_arbiter #(.N_SLOTS(N_SLOTS)) u_arbiter (
      .arb(arb_bus)
   );

   // -------------------------------------------------------------------------
   // presented request
   // -------------------------------------------------------------------------
   logic next_valid;
   logic [6:0] next_num;
   logic [4:0] next_prio;
   logic [31:0] next_vec;

   always_comb begin
      // drop the winner in the take cycle; pend is stale until the next edge
      next_valid = arb_bus.valid & ~taken;
      next_num = arb_bus.num;
      next_prio = arb_bus.win_prio;
      next_vec = vim_pkg::vec_of_num(arb_bus.num); // see RULE_03
   end

   always_ff @(posedge mclk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_valid_o <= 1'b0;
         irq_num_o <= 7'h00;
         irq_prio_o <= 5'h00;
         vec_addr_o <= 32'h00000000;
         line_pend_o <= '0;
      end else begin
         irq_valid_o <= next_valid;
         irq_num_o <= next_num;
         irq_prio_o <= next_prio;
         vec_addr_o <= next_vec;
         line_pend_o <= next_pend[N_SLOTS-1:`VIM_NUM_SYS];
      end
   end

   // -------------------------------------------------------------------------
   // checks
   // -------------------------------------------------------------------------
   logic [NUM_LINES-1:0][3:0] line_prio_q;

   always_ff @(posedge mclk_i) begin
      line_prio_q <= line_prio_i;
   end

   default clocking cb @(posedge mclk_i);
   endclocking

   default disable iff (!rst_n);

   sequence s_out_of_reset;
      !$past(rst_n) ##1 1'b1;
   endsequence

   sequence s_reset_vector;
      irq_valid_o && irq_num_o == `VIM_EXC_RESET && irq_prio_o == `VIM_PRIO_RESET;
   endsequence

   a_line_bound: assert property (irq_valid_o |-> irq_num_o < 7'(N_SLOTS)) // see RULE_01
      else $error("presented number beyond the last line");

   a_line_prio: assert property (irq_valid_o && irq_num_o >= 7'h10 |-> // see RULE_02
      irq_prio_o == {1'b0, line_prio_q[irq_num_o - 7'h10]})
      else $error("line priority differs from its setting");

   a_line_vector: assert property (irq_valid_o && irq_num_o >= 7'h10 |-> // see RULE_03
      vec_addr_o == `VIM_LINE_VEC_BASE + {23'h000000, irq_num_o - 7'h10, 2'b00})
      else $error("line vector not at 0x40 plus four times line");

   a_supply_line: assert property (supply_monitor_req_i |=> line_pend_o[`VIM_LINE_SUPPLY]) // see RULE_03
      else $error("supply monitor request did not pend line 1");

   a_usb_can_share: assert property (usb_high_prio_req_i || can_tx_req_i |=> // see RULE_04
      line_pend_o[`VIM_LINE_USB_CAN])
      else $error("usb or can request did not pend line 19");

   a_pins_five_nine: assert property (|pin_lines_five_to_nine_req_i |=> // see RULE_05
      line_pend_o[`VIM_LINE_PIN5_9])
      else $error("pin lines five to nine did not pend line 23");

   a_pins_ten_fifteen: assert property (|pin_lines_ten_to_fifteen_req_i |=> // see RULE_06
      line_pend_o[`VIM_LINE_PIN10_15])
      else $error("pin lines ten to fifteen did not pend line 40");

   a_flash_vector: assert property (irq_valid_o && irq_num_o == 7'h14 |-> // see RULE_07
      vec_addr_o == `VIM_LINE_VEC_BASE + 32'(4 * `VIM_LINE_FLASH))
      else $error("flash line not given its own vector slot");

   a_flash_pend: assert property (flash_req_i |=> line_pend_o[`VIM_LINE_FLASH]) // see RULE_07
      else $error("flash request lost");

   // a request reaches irq_* two edges after it is sampled, hence depth two
   a_fixed_outrank: assert property (irq_valid_o && irq_num_o >= 7'h04 |-> // see RULE_08
      !$past(nmi_i, 2) && !$past(hard_fault_i, 2))
      else $error("fixed exception outranked by a programmable one");

   a_reset_first: assert property (s_out_of_reset |-> ##[1:3] s_reset_vector) // see RULE_08
      else $error("reset vector not presented first");

   a_take_drops: assert property (take_i && irq_valid_o |=> !irq_valid_o) // see RULE_01
      else $error("presented request not withdrawn after take");

endmodule : vim_mapper

`default_nettype wire

// ==== verification/vim_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------------
// core side: takes whatever the mapper presents
// ----------------------------------------------------------------------------
module vim_core_model (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic irq_valid_i,
   input wire logic stall_i,
   output logic take_o
);
   // one-cycle pulse, never twice in a row, so takes stay two cycles apart;
   // stall_i models a core still busy in a handler
   always @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         take_o <= 1'b0;
      end else begin
         take_o <= irq_valid_i && !take_o && !stall_i;
      end
   end
endmodule : vim_core_model

`default_nettype wire

// ==== verification/vim_mapper_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module vim_mapper_tb;
   typedef struct packed {
      logic [6:0] num;
      logic [4:0] prio;
      logic [31:0] vec;
   } vim_tb_exp_s;

   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic [64:0] per_req = '0;
   logic [64:0] line_en = '1;
   logic [64:0][3:0] line_prio;
   logic supply = 1'b0, flash = 1'b0, usb = 1'b0, can = 1'b0, nmi = 1'b0, hard = 1'b0;
   logic [4:0] pin59 = '0;
   logic [5:0] pin1015 = '0;
   logic [6:0] sys_req = '0;
   logic [6:0][3:0] sys_prio;
   logic take, stall = 1'b0, irq_valid;
   logic [6:0] irq_num;
   logic [4:0] irq_prio;
   logic [31:0] vec_addr;
   logic [64:0] line_pend;
   logic [7:0] rnd = 8'h59;
   logic [6:0] sys_num [7] = '{7'h04, 7'h05, 7'h06, 7'h0b, 7'h0c, 7'h0e, 7'h0f};
   vim_tb_exp_s exp_q [$];
   vim_tb_exp_s e;
   int fails = 0;
   int cmp_count = 0;

   always #25 mclk = ~mclk;

   vim_mapper DUT (.mclk_i(mclk), .rst_n_i(rst_n), .per_req_i(per_req),
      .supply_monitor_req_i(supply), .flash_req_i(flash), .usb_high_prio_req_i(usb),
      .can_tx_req_i(can), .pin_lines_five_to_nine_req_i(pin59),
      .pin_lines_ten_to_fifteen_req_i(pin1015), .line_en_i(line_en),
      .line_prio_i(line_prio), .nmi_i(nmi), .hard_fault_i(hard), .sys_req_i(sys_req),
      .sys_prio_i(sys_prio), .take_i(take), .irq_valid_o(irq_valid), .irq_num_o(irq_num),
      .irq_prio_o(irq_prio), .vec_addr_o(vec_addr), .line_pend_o(line_pend));

   vim_core_model core (.mclk_i(mclk), .rst_n_i(rst_n), .irq_valid_i(irq_valid),
      .stall_i(stall), .take_o(take));

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   task automatic chk(input logic [31:0] seen, input logic [31:0] expv);
      cmp_count++;
      if (seen !== expv) begin
         fails++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, expv);
      end
   endtask : chk

   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : complete_run

   task automatic expect_line(input int n);
      exp_q.push_back('{7'(16 + n), {1'b0, line_prio[n]}, 32'h40 + 32'(n) * 4});
   endtask : expect_line

   task automatic expect_sys(input logic [6:0] num, input logic [4:0] prio);
      exp_q.push_back('{num, prio, 32'(num) * 4});
   endtask : expect_sys

   // a lost request would otherwise hang here, so the wait is bounded
   task automatic wait_drain;
      for (int i = 0; i < 40 && exp_q.size() > 0; i++) @(posedge mclk);
      chk(32'(exp_q.size()), 32'h0);
      exp_q.delete();
   endtask : wait_drain

   task automatic pulse(input int src, input int idx);
      @(posedge mclk);
      case (src)
         0: per_req[idx] <= 1'b1;
         1: supply <= 1'b1;
         2: flash <= 1'b1;
         3: usb <= 1'b1;
         4: can <= 1'b1;
         5: pin59[idx] <= 1'b1;
         6: pin1015[idx] <= 1'b1;
         7: nmi <= 1'b1;
         8: hard <= 1'b1;
         default: sys_req[idx] <= 1'b1;
      endcase
      @(posedge mclk);
      {per_req, supply, flash, usb, can, pin59, pin1015, nmi, hard, sys_req} <= '0;
      wait_drain;
   endtask : pulse

   // ----------------------------------------------------------------------------
   // checker: one note used up per take
   // ----------------------------------------------------------------------------
   always @(posedge mclk) begin
      if (take === 1'b1 && irq_valid === 1'b1) begin
         // an extra take meets an impossible note, so it counts as a mismatch
         if (exp_q.size() != 0) begin
            e = exp_q.pop_front();
         end else begin
            e = '{7'h7f, 5'h00, 32'hffffffff};
         end
         chk(32'(irq_num), 32'(e.num));
         chk(32'(irq_prio), 32'(e.prio));
         chk(vec_addr, e.vec);
      end
   end

   initial begin
      for (int i = 0; i < 65; i++) begin
         rnd = lfsr(rnd);
         line_prio[i] <= rnd[3:0];
      end
      for (int k = 0; k < 7; k++) begin
         rnd = lfsr(rnd);
         sys_prio[k] <= rnd[7:4];
      end
      expect_sys(7'h01, 5'h1d);
      repeat (2) @(posedge mclk);
      rst_n <= 1'b1;
      wait_drain;
      for (int n = 0; n < 65; n++) begin
         if (!(n inside {1, 4, 19, 23, 40})) begin
            expect_line(n);
            pulse(0, n);
         end
      end
      expect_line(1);
      pulse(1, 0);
      expect_line(4);
      pulse(2, 0);
      expect_line(19);
      pulse(3, 0);
      expect_line(19);
      pulse(4, 0);
      for (int i = 0; i < 5; i++) begin
         expect_line(23);
         pulse(5, i);
      end
      for (int i = 0; i < 6; i++) begin
         expect_line(40);
         pulse(6, i);
      end
      expect_sys(7'h02, 5'h1e);
      pulse(7, 0);
      expect_sys(7'h03, 5'h1f);
      pulse(8, 0);
      for (int k = 0; k < 7; k++) begin
         expect_sys(sys_num[k], {1'b0, sys_prio[k]});
         pulse(9, k);
      end
      // masked line pends but stays hidden until enabled
      @(posedge mclk);
      line_en[30] <= 1'b0;
      pulse(0, 30);
      repeat (3) @(posedge mclk);
      chk(32'(line_pend[30]), 32'h1);
      chk(32'(irq_valid), 32'h0);
      expect_line(30);
      line_en[30] <= 1'b1;
      wait_drain;
      // stalled core: nmi first, then lowest value, ties to lower number
      @(posedge mclk);
      stall <= 1'b1;
      line_prio[50] <= 4'h2;
      line_prio[51] <= 4'h2;
      line_prio[52] <= 4'h1;
      @(posedge mclk);
      per_req[52:50] <= 3'b111;
      nmi <= 1'b1;
      @(posedge mclk);
      per_req <= '0;
      nmi <= 1'b0;
      repeat (4) @(posedge mclk);
      expect_sys(7'h02, 5'h1e);
      expect_line(52);
      expect_line(50);
      expect_line(51);
      stall <= 1'b0;
      wait_drain;
      complete_run;
   end

   initial begin
      #(50 * 20000);
      fails++;
      complete_run;
   end
endmodule : vim_mapper_tb

`default_nettype wire
